//--- prc_consts.svh
// constants for the pulse program run-control block
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH
// ==========================================================
// register map (word aligned byte offsets)
`define PRC_ADDR_CTRL      4'h0
`define PRC_ADDR_STATUS    4'h4
`define PRC_ADDR_PATTERN   4'h8
`define PRC_ADDR_OPCODE    4'hC
// ctrl register bits (write-one pulses)
`define PRC_CTRL_START     0
`define PRC_CTRL_CLEAR     1
`define PRC_CTRL_LOAD      2
`define PRC_CTRL_TRIG      3
// status register bits
`define PRC_STS_RESET      0
`define PRC_STS_RUN        1
`define PRC_STS_WAIT       2
// opcodes
`define PRC_OP_HALT        4'h1
`define PRC_OP_PAUSE       4'h8
// reset values
`define PRC_PATTERN_RST    24'h000000
`define PRC_OPCODE_RST     4'h0
// reference and core clock rates
`define PRC_REF_MHZ        50
`define PRC_CLK_MHZ        20
`endif

//--- prc_pkg.sv
// types for the pulse program run-control block
package prc_pkg;
  // ==========================================================
  // sequencer states, gray along reset->idle->run->pause
  typedef enum logic [1:0]
  {
    PRC_RESET = 2'b00,
    PRC_IDLE  = 2'b01,
    PRC_RUN   = 2'b11,
    PRC_PAUSE = 2'b10
  } prc_state_e;
  // status lines grouped
  typedef struct packed
  {
    logic wait_trig;
    logic running;
    logic in_reset;
  } prc_status_s;
endpackage : prc_pkg

//--- prc_run_control.sv
// run-control, status and output mapping of the pulse sequencer
//
// Behaviour
// RULE1: pattern bits 0..15 on low16 group
// RULE2: pattern bits 0..11 on low12 group
// RULE3: pattern bits 12..23 on high12 group
// RULE4: reference clock driven out on dedicated pin; code drives out a copy of it sampled on i_mclk
// RULE5: reset status high until program reloaded
// RULE6: running high executing, low reset/idle
// RULE7: paused high while waiting for trigger
// RULE8: running stays high during pause wait
// RULE9: all three trigger pins act identically
// RULE10: trigger in idle restarts from start
// RULE11: halt or hardware clear enters idle
// RULE12: host clears after halt before triggering
// RULE13: trigger while paused advances one instruction
// RULE14: both clear pins act identically
// RULE15: clear during run returns counter to zero
// RULE16: after clear, start or trigger restarts
// RULE17: opcode 1 is halt, goes idle
// RULE18: opcode 8 is pause for trigger
// RULE19: inputs synchronised, one event per pulse
// RULE20: clear wins over simultaneous trigger
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`include "prc_consts.svh"
module prc_run_control
#(
  parameter int PC_W = 12                                   // program counter width
)
(
  input  wire logic                i_mclk,                  // core clock
  input  wire logic                i_srst,                  // sync reset, high
  input  wire logic                i_ref_clk_50,            // 50 MHz reference
  input  wire logic                i_trigger_in_active_low, // trigger, low pulse
  input  wire logic [1:0]          i_trigger_in_active_high,// triggers, high pulse
  input  wire logic                i_clear_in_active_low,   // clear, low pulse
  input  wire logic                i_clear_in_active_high,  // clear, high pulse
  input  wire logic [31:0]         i_wb_adr,                // wishbone address
  input  wire logic [31:0]         i_wb_dat,                // wishbone write data
  input  wire logic [3:0]          i_wb_sel,                // byte selects
  input  wire logic                i_wb_we,                 // write enable
  input  wire logic                i_wb_cyc,                // cycle
  input  wire logic                i_wb_stb,                // strobe
  output logic [31:0]              o_wb_dat,                // read data
  output logic                     o_wb_ack,                // acknowledge
  output logic                     o_ref_clk_out,           // reference clock out
  output logic [15:0]              o_output_group_low16,    // connector bits 0..15
  output logic [11:0]              o_output_group_low12,    // header bits 0..11
  output logic [11:0]              o_output_group_high12,   // header bits 12..23
  output prc_pkg::prc_status_s     o_status_group,          // reset/running/waiting
  output logic [PC_W-1:0]          o_pc                     // program counter
);
  import prc_pkg::*;

  // ==========================================================
  // input synchronisers and edge detect
  logic [4:0] pin_act;            // active-high view of pins
  logic [4:0] sync1_r, sync1_nxt; // first stage
  logic [4:0] sync2_r, sync2_nxt; // second stage
  logic [4:0] last_r,  last_nxt;  // previous synced value
  logic       trig_ev;            // one trigger event
  logic       clr_ev;             // one clear event

  // normalise polarity so every pin is active high
  always_comb
  begin
    pin_act = {i_clear_in_active_high, ~i_clear_in_active_low,
               i_trigger_in_active_high, ~i_trigger_in_active_low}; // RULE9 RULE14
    sync1_nxt = pin_act;
    sync2_nxt = sync1_r;
    last_nxt  = sync2_r;
  end

  // sync registers; idle level is inactive
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      last_r  <= 5'h00;
    end
    else
    begin
      sync1_r <= sync1_nxt; // RULE19
      sync2_r <= sync2_nxt;
      last_r  <= last_nxt;
    end
  end

  // rising edge of any pin gives one event
  function automatic logic any_rise(input logic [4:0] cur, input logic [4:0] prv, input logic [4:0] msk);
    any_rise = |(cur & ~prv & msk);
  endfunction : any_rise

  assign trig_ev = any_rise(sync2_r, last_r, 5'h07); // RULE19 RULE9
  assign clr_ev  = any_rise(sync2_r, last_r, 5'h18); // RULE19 RULE14

  // ==========================================================
  // reference clock forwarding
  logic rsync1_r, rsync2_r; // ref clock samples

  // sampled copy of the reference; true forwarding needs a pll
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      rsync1_r <= 1'b0;
      rsync2_r <= 1'b0;
    end
    else
    begin
      rsync1_r <= i_ref_clk_50;
      rsync2_r <= rsync1_r; // RULE4
    end
  end

  // ==========================================================
  // wishbone slave
  logic              ack_r, ack_nxt;        // ack
  logic [31:0]       rdat_r, rdat_nxt;      // read data
  logic [23:0]       pattern_r, pattern_nxt;// current pattern
  logic [3:0]        opcode_r, opcode_nxt;  // current opcode
  logic              sw_start;              // software start
  logic              sw_clear;              // software clear
  logic              sw_load;               // memory reloaded
  logic              sw_trig;               // software trigger
  logic              wr_ctrl;               // ctrl write
  prc_status_s       sts;                   // live status

  // decode a word address
  function automatic logic hit(input logic [31:0] a, input logic [3:0] off);
    hit = (a[31:4] == 28'h0000000) && (a[3:0] == off);
  endfunction : hit

  // access pulse and ctrl commands
  always_comb
  begin
    wr_ctrl  = i_wb_cyc && i_wb_stb && !ack_r && i_wb_we && i_wb_sel[0] && hit(i_wb_adr, `PRC_ADDR_CTRL);
    sw_start = wr_ctrl && i_wb_dat[`PRC_CTRL_START];
    sw_clear = wr_ctrl && i_wb_dat[`PRC_CTRL_CLEAR];
    sw_load  = wr_ctrl && i_wb_dat[`PRC_CTRL_LOAD];
    sw_trig  = wr_ctrl && i_wb_dat[`PRC_CTRL_TRIG];
  end

  // register writes and read mux
  always_comb
  begin
    ack_nxt     = i_wb_cyc && i_wb_stb && !ack_r;
    rdat_nxt    = rdat_r;
    pattern_nxt = pattern_r;
    opcode_nxt  = opcode_r;
    if (ack_nxt && i_wb_we)
    begin
      // pattern register, byte lanes
      if (hit(i_wb_adr, `PRC_ADDR_PATTERN))
      begin
        if (i_wb_sel[0]) pattern_nxt[7:0]   = i_wb_dat[7:0];
        if (i_wb_sel[1]) pattern_nxt[15:8]  = i_wb_dat[15:8];
        if (i_wb_sel[2]) pattern_nxt[23:16] = i_wb_dat[23:16];
      end
      // opcode of current instruction
      if (hit(i_wb_adr, `PRC_ADDR_OPCODE) && i_wb_sel[0])
        opcode_nxt = i_wb_dat[3:0];
    end
    else if (ack_nxt)
    begin
      // reads; unmapped reads zero
      if (hit(i_wb_adr, `PRC_ADDR_STATUS))
        rdat_nxt = {29'h0, sts};
      else if (hit(i_wb_adr, `PRC_ADDR_PATTERN))
        rdat_nxt = {8'h00, pattern_r};
      else if (hit(i_wb_adr, `PRC_ADDR_OPCODE))
        rdat_nxt = {28'h0, opcode_r};
      else
        rdat_nxt = 32'h00000000;
    end
  end

  // bus registers
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      ack_r     <= 1'b0;
      rdat_r    <= 32'h00000000;
      pattern_r <= `PRC_PATTERN_RST;
      opcode_r  <= `PRC_OPCODE_RST;
    end
    else
    begin
      ack_r     <= ack_nxt;
      rdat_r    <= rdat_nxt;
      pattern_r <= pattern_nxt;
      opcode_r  <= opcode_nxt;
    end
  end

  // ==========================================================
  // sequencer state machine
  prc_state_e      state_r, state_nxt; // run state
  logic [PC_W-1:0] pc_r, pc_nxt;       // program counter
  logic            step;               // advance one instruction
  logic            any_trig;           // hardware or software trigger
  logic            any_clr;            // hardware or software clear

  // next state and counter
  always_comb
  begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    any_trig  = trig_ev || sw_trig;
    any_clr   = clr_ev || sw_clear;
    step      = 1'b0;
    case (state_r)
      PRC_RESET:
      begin
        pc_nxt = '0; // held until memory reloaded
        if (sw_load)
          state_nxt = PRC_IDLE; // RULE5
      end
      PRC_IDLE:
      begin
        // counter parked on the first instruction
        pc_nxt = '0;
        if (any_trig || sw_start)
          state_nxt = PRC_RUN; // RULE10 RULE16
      end
      PRC_RUN:
      begin
        // halt parks the sequencer in idle
        if (opcode_r == `PRC_OP_HALT)
          state_nxt = PRC_IDLE; // RULE17 RULE11 RULE12
        else if (opcode_r == `PRC_OP_PAUSE)
          state_nxt = PRC_PAUSE; // RULE18
        else
          step = 1'b1;
      end
      PRC_PAUSE:
      begin
        // only a trigger steps past the pause
        if (any_trig)
        begin
          state_nxt = PRC_RUN; // RULE13
          step      = 1'b1;
        end
      end
      default:
        state_nxt = PRC_RESET;
    endcase
    if (step)
      pc_nxt = pc_r + 1'b1;
    // a clear outside reset abandons the program and beats a trigger
    if (any_clr && state_r != PRC_RESET)
    begin
      state_nxt = PRC_IDLE; // RULE11 RULE15 RULE20
      pc_nxt    = '0;
    end
  end

  // sequencer registers
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      state_r <= PRC_RESET;
      pc_r    <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
    end
  end

  // live status from state
  always_comb
  begin
    sts.in_reset  = (state_r == PRC_RESET);                           // RULE5
    sts.running   = (state_r == PRC_RUN) || (state_r == PRC_PAUSE);   // RULE6 RULE8
    sts.wait_trig = (state_r == PRC_PAUSE);                           // RULE7
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_output_group_low16  <= 16'h0000;
      o_output_group_low12  <= 12'h000;
      o_output_group_high12 <= 12'h000;
      o_status_group        <= 3'h1;
      o_ref_clk_out         <= 1'b0;
      o_pc                  <= '0;
    end
    else
    begin
      o_output_group_low16  <= pattern_nxt[15:0];  // RULE1
      o_output_group_low12  <= pattern_nxt[11:0];  // RULE2
      o_output_group_high12 <= pattern_nxt[23:12]; // RULE3
      o_status_group        <= sts;
      o_ref_clk_out         <= rsync2_r;           // RULE4
      o_pc                  <= pc_nxt;
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;
  // ==========================================================
  // assertions
  sequence s_paused;
    state_r == PRC_PAUSE;
  endsequence

  a_pause_runs_high: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_paused |=> o_status_group.running) else $error("running low while paused"); // RULE8
  a_wait_flag_set: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_paused |=> o_status_group.wait_trig) else $error("waiting low while paused"); // RULE7
  a_clear_beats_trig: assert property (@(posedge i_mclk) disable iff (i_srst)
    (clr_ev && trig_ev && state_r != PRC_RESET) |=> (state_r == PRC_IDLE && pc_r == '0))
    else $error("trigger not ignored on clear"); // RULE20
  a_halt_stops_run: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state_r == PRC_RUN && !any_clr && opcode_r == `PRC_OP_HALT) |=> ##1 !o_status_group.running)
    else $error("halt did not stop"); // RULE17
  a_idle_trig_start: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state_r == PRC_IDLE && trig_ev && !any_clr) |=> (state_r == PRC_RUN && pc_r == '0))
    else $error("idle trigger did not restart"); // RULE10
  a_pause_trig_step: assert property (@(posedge i_mclk) disable iff (i_srst)
    (s_paused and (trig_ev && !any_clr)) |=> (pc_r == $past(pc_r) + 1'b1))
    else $error("paused trigger did not advance"); // RULE13
  a_low16_follows: assert property (@(posedge i_mclk) disable iff (i_srst)
    ##1 (o_output_group_low16 == pattern_r[15:0])) else $error("low16 mismatch"); // RULE1
  a_high12_follows: assert property (@(posedge i_mclk) disable iff (i_srst)
    ##1 (o_output_group_high12 == pattern_r[23:12] && o_output_group_low12 == pattern_r[11:0]))
    else $error("header group mismatch"); // RULE2 RULE3
  a_single_event: assert property (@(posedge i_mclk) disable iff (i_srst)
    trig_ev |=> !trig_ev) else $error("trigger event longer than one cycle"); // RULE19
endmodule : prc_run_control

//--- prc_ext_equip.sv
// model of the lab equipment driving trigger and clear pins
`timescale 1ns/1ns
module prc_ext_equip
(
  input  wire logic       i_mclk,   // core clock, pacing only
  output logic            o_trig_n, // trigger, low active
  output logic [1:0]      o_trig_h, // triggers, high active
  output logic            o_clr_n,  // clear, low active
  output logic            o_clr_h   // clear, high active
);
  // ==========================================================
  // pins rest at their pull levels
  initial
  begin
    o_trig_n = 1'b1;
    o_trig_h = 2'h0;
    o_clr_n  = 1'b1;
    o_clr_h  = 1'b0;
  end
  // ==========================================================
  // pulse: mask 0 trig_n, 1..2 trig_h, 3 clr_n, 4 clr_h
  task automatic pulse(input logic [4:0] m, input int w);
    @(posedge i_mclk);
    o_trig_n <= ~m[0];
    o_trig_h <= m[2:1];
    o_clr_n  <= ~m[3];
    o_clr_h  <= m[4];
    repeat (w) @(posedge i_mclk);
    o_trig_n <= 1'b1;
    o_trig_h <= 2'h0;
    o_clr_n  <= 1'b1;
    o_clr_h  <= 1'b0;
    // let sync, edge detect and status settle
    repeat (5) @(posedge i_mclk);
  endtask : pulse
endmodule : prc_ext_equip

//--- prc_run_control_tb.sv
// self-checking bench for the run-control block
`timescale 1ns/1ns
`include "prc_consts.svh"
module prc_run_control_tb;
  import prc_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic        mclk = 1'b0;     // core clock
  logic        srst = 1'b1;     // sync reset
  logic        ref_clk = 1'b0;  // reference in
  logic [31:0] wb_adr = '0;     // bus address
  logic [31:0] wb_dw = '0;      // bus write data
  logic        wb_we = 1'b0;    // write enable
  logic        wb_cyc = 1'b0;   // cycle
  logic        wb_stb = 1'b0;   // strobe
  logic [31:0] wb_dr;           // read data
  logic        wb_ack;          // acknowledge
  logic        ref_out;         // reference out
  logic [15:0] low16;           // connector group
  logic [11:0] low12;           // low header
  logic [11:0] high12;          // high header
  prc_status_s sts;             // status lines
  logic [11:0] pc;              // program counter
  logic        trig_n;          // trigger pins
  logic [1:0]  trig_h;
  logic        clr_n;           // clear pins
  logic        clr_h;
  int          bad_count = 0;   // mismatches
  int          checks_done = 0; // comparisons
  always #25 mclk = ~mclk;
  always #10 ref_clk = ~ref_clk;
  // ==========================================================
  // design and far-side model
  prc_run_control #(.PC_W(12)) prc_run_control_i (.i_mclk(mclk), .i_srst(srst),
    .i_ref_clk_50(ref_clk), .i_trigger_in_active_low(trig_n),
    .i_trigger_in_active_high(trig_h), .i_clear_in_active_low(clr_n),
    .i_clear_in_active_high(clr_h), .i_wb_adr(wb_adr), .i_wb_dat(wb_dw),
    .i_wb_sel(4'hF), .i_wb_we(wb_we), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .o_wb_dat(wb_dr), .o_wb_ack(wb_ack), .o_ref_clk_out(ref_out),
    .o_output_group_low16(low16), .o_output_group_low12(low12),
    .o_output_group_high12(high12), .o_status_group(sts), .o_pc(pc));
  prc_ext_equip prc_ext_equip_i (.i_mclk(mclk), .o_trig_n(trig_n),
    .o_trig_h(trig_h), .o_clr_n(clr_n), .o_clr_h(clr_h));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic [31:0] a, input logic we, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge mclk);
    wb_adr <= a;
    wb_dw  <= d;
    wb_we  <= we;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    @(posedge mclk);
    while (wb_ack !== 1'b1)
      @(posedge mclk);
    q = wb_dr;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
    repeat (5) @(posedge mclk);
  endtask : wr
  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // scenarios
  task automatic t_map();
    logic [23:0] p[3] = '{24'hA5C3F1, 24'h5A3C0E, 24'hFFFFFF};
    logic [31:0] q;
    chk("rst status", sts, 3'h1);
    wb(32'h00000010, 1'b0, 32'h0, q);
    chk("unmapped", q, 32'h0);
    foreach (p[i])
    begin
      wb(`PRC_ADDR_PATTERN, 1'b1, p[i], q);
      @(posedge mclk);
      chk("low16", low16, p[i][15:0]);
      chk("low12", low12, p[i][11:0]);
      chk("high12", high12, p[i][23:12]);
      wb(`PRC_ADDR_PATTERN, 1'b0, 32'h0, q);
      chk("pattern rd", q, p[i]);
    end
  endtask : t_map
  // the forwarded reference must keep toggling
  task automatic t_ref();
    int   n = 0;
    logic prv;
    prv = ref_out;
    repeat (20)
    begin
      @(posedge mclk);
      if (ref_out !== prv)
        n++;
      prv = ref_out;
    end
    chk("ref out", n >= 2, 1'b1);
  endtask : t_ref
  // each trigger pin restarts from idle, clear pins stop
  task automatic t_trig();
    wr(`PRC_ADDR_CTRL, 32'h1 << `PRC_CTRL_LOAD);
    chk("idle", sts, 3'h0);
    for (int i = 0; i < 3; i++)
    begin
      prc_ext_equip_i.pulse(5'h01 << i, 3);
      chk("run", sts, 3'h2);
      chk("restart", pc < 12'h020, 1'b1);
      prc_ext_equip_i.pulse(i == 1 ? 5'h10 : 5'h08, 3);
      chk("clr idle", sts, 3'h0);
      chk("clr pc", pc, 12'h000);
    end
  endtask : t_trig
  // pause, single advance on a held pin, clear, halt
  task automatic t_pause();
    logic [11:0] p;
    prc_ext_equip_i.pulse(5'h01, 3);
    wr(`PRC_ADDR_OPCODE, `PRC_OP_PAUSE);
    p = pc;
    chk("pause", sts, 3'h6);
    prc_ext_equip_i.pulse(5'h04, 20);
    chk("advance", pc, p + 12'h001);
    chk("repause", sts, 3'h6);
    prc_ext_equip_i.pulse(5'h10, 3);
    chk("clr pause", sts, 3'h0);
    chk("clr pc", pc, 12'h000);
    wr(`PRC_ADDR_OPCODE, `PRC_OPCODE_RST);
    wr(`PRC_ADDR_CTRL, 32'h1 << `PRC_CTRL_START);
    chk("sw start", sts, 3'h2);
    wr(`PRC_ADDR_OPCODE, `PRC_OP_HALT);
    chk("halt", sts, 3'h0);
    wr(`PRC_ADDR_OPCODE, `PRC_OPCODE_RST);
    wr(`PRC_ADDR_CTRL, 32'h1 << `PRC_CTRL_CLEAR);
    prc_ext_equip_i.pulse(5'h02, 3);
    chk("halt trig", sts, 3'h2);
    // back to idle, then clear and trigger in one cycle
    prc_ext_equip_i.pulse(5'h10, 3);
    prc_ext_equip_i.pulse(5'h09, 3);
    chk("clr wins", sts, 3'h0);
  endtask : t_pause
  // reset in mid-run, then a trigger must be ignored until reload
  task automatic t_rst();
    prc_ext_equip_i.pulse(5'h01, 3);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    prc_ext_equip_i.pulse(5'h04, 3);
    chk("rst trig", sts, 3'h1);
    chk("rst pc", pc, 12'h000);
  endtask : t_rst
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_map();
    t_ref();
    t_trig();
    t_pause();
    t_rst();
    wrap_up();
  end
  initial
  begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    wrap_up();
  end
endmodule : prc_run_control_tb
